// ---- hw/mmm_map.svh ----
// Purpose: constants of the mixed mode multiplier: offsets, fields, widths, reset values
// Assumes: 32-bit avalon data bus, byte addresses, one register per aligned word
// Notes: included by bare name from every design file that needs it
// Overview of operation
// RULE1 - each operand is signed or unsigned by its own format select
// RULE2 - product always comes out in two's complement, whatever the formats
// RULE3 - controller loads operands, then strobes the product register
// RULE4 - an operand register that is not loaded keeps its value
// RULE5 - shift control active: upper product half moves one place left
// RULE6 - shift control active: top bit of lower half is the next product bit
// RULE7 - shift control inactive: top bit of lower half copies the sign
// RULE8 - controller holds shift control high for unsigned by unsigned
// RULE9 - flow-through high makes the product register follow the product
// RULE10 - flow-through gives valid outputs without any product strobe
// RULE11 - operand registers and selects load on their strobe; product likewise
`ifndef MMM_MAP_SVH
`define MMM_MAP_SVH

`define MMM_OPW            16
`define MMM_PRODW          33

`define MMM_ADDR_W         5
`define MMM_OFS_MCAND      5'h00
`define MMM_OFS_MPLIER     5'h04
`define MMM_OFS_CTRL       5'h08
`define MMM_OFS_PSTROBE    5'h0C
`define MMM_OFS_PRODUCT    5'h10
`define MMM_OFS_STATUS     5'h14

`define MMM_FLD_SIGNED     16
`define MMM_FLD_SHIFT      0
`define MMM_FLD_FLOW       1

`define MMM_RST_OPER       16'h0000
`define MMM_RST_HALF       16'h0000
`define MMM_RST_SHIFT      1'b1
`define MMM_RST_FLOW       1'b0
`define MMM_RST_DATA       32'h0000_0000

`endif

// ---- hw/mmm_pkg.sv ----
// Purpose: shared types of the mixed mode multiplier
// Assumes: widths from mmm_map.svh
// Notes: used only with explicit package scope
`include "mmm_map.svh"
package mmm_pkg;
   typedef logic [`MMM_OPW-1:0]   mmm_oper_t;
   typedef logic [`MMM_PRODW-1:0] mmm_prod_t;
   typedef enum logic [1:0] {
      MMM_BUS_IDLE,
      MMM_BUS_ANSWER
   } mmm_bus_state_t;
endpackage : mmm_pkg

// ---- hw/mmm_oper_if.sv ----
// Purpose: carries one held operand and its format select
// Assumes: single clock domain
// Notes: src is the operand register, dst the product unit
`timescale 1ns/1ps
interface mmm_oper_if;
   mmm_pkg::mmm_oper_t value;
   logic               signed_sel;
   modport src (output value, output signed_sel);
   modport dst (input value, input signed_sel);
endinterface : mmm_oper_if

// ---- hw/mmm_oper_reg.sv ----
// Purpose: one operand register with its format select
// Assumes: load is a one-cycle strobe standing in for the operand clock edge
// Notes: no load, no change, so a constant operand can sit here indefinitely
`timescale 1ns/1ps
`include "mmm_map.svh"
module mmm_oper_reg (
   input  wire logic               ref_clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               ce_i,
   input  wire logic               load_i,
   input  wire mmm_pkg::mmm_oper_t data_i,
   input  wire logic               signed_sel_i,
   mmm_oper_if.src                 oper
);
   mmm_pkg::mmm_oper_t value_q;
   logic               signed_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         value_q  <= `MMM_RST_OPER;
         signed_q <= 1'b0;
      end else if (ce_i && load_i) begin
         value_q  <= data_i;        // RULE11
         signed_q <= signed_sel_i;  // RULE11
      end                           // RULE4
   end

   assign oper.value      = value_q;
   assign oper.signed_sel = signed_q;
endmodule : mmm_oper_reg

// ---- hw/mmm_prod_unit.sv ----
// Purpose: mixed mode array product, result formatting and product register
// Assumes: operands held by mmm_oper_reg instances
// Notes: flow-through reloads every enabled cycle, so outputs lag the operands by one cycle
`timescale 1ns/1ps
`include "mmm_map.svh"
module mmm_prod_unit (
   input  wire logic               ref_clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               ce_i,
   mmm_oper_if.dst                 mcand,
   mmm_oper_if.dst                 mplier,
   input  wire logic               result_shift_ctl_i,
   input  wire logic               flow_through_ctl_i,
   input  wire logic               strobe_i,
   output logic [`MMM_OPW-1:0]     upper_product_half_o,
   output logic [`MMM_OPW-1:0]     lower_product_half_o
);
   localparam int W = `MMM_OPW;

   // one extra bit per operand lets a single signed multiply cover all four mixes
   function automatic logic signed [W:0] extend(input logic [W-1:0] v, input logic s);
      extend = {s & v[W-1], v};
   endfunction : extend

   logic signed [2*W+1:0]   full_w;
   mmm_pkg::mmm_prod_t      prod_w;
   logic [W-1:0]            upper_w;
   logic [W-1:0]            lower_w;
   logic                    load_w;
   logic [W-1:0]            upper_q;
   logic [W-1:0]            lower_q;

   assign full_w = extend(mcand.value, mcand.signed_sel)
                 * extend(mplier.value, mplier.signed_sel);      // RULE1
   assign prod_w = full_w[`MMM_PRODW-1:0];                       // RULE2
   assign upper_w = result_shift_ctl_i ? prod_w[2*W-1:W]         // RULE5
                                       : prod_w[2*W:W+1];
   assign lower_w = result_shift_ctl_i ? prod_w[W-1:0]           // RULE6
                                       : {prod_w[2*W], prod_w[W:2]}; // RULE7
   assign load_w = strobe_i | flow_through_ctl_i;                // RULE9 RULE10

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         upper_q <= `MMM_RST_HALF;
         lower_q <= `MMM_RST_HALF;
      end else if (ce_i && load_w) begin
         upper_q <= upper_w;  // RULE11
         lower_q <= lower_w;
      end
   end

   assign upper_product_half_o = upper_q;
   assign lower_product_half_o = lower_q;
endmodule : mmm_prod_unit

// ---- hw/mmm_top.sv ----
// Purpose: mixed mode multiplier with an avalon-mm register port
// Assumes: ref_clk_i at 250 MHz, synchronous active-low reset, ce_i freezes all state
// Notes: every access answers with exactly one wait cycle while ce_i stays high
`timescale 1ns/1ps
`include "mmm_map.svh"
module mmm_top (
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   ce_i,
   input  wire logic [`MMM_ADDR_W-1:0] avs_address_i,
   input  wire logic                   avs_read_i,
   input  wire logic                   avs_write_i,
   input  wire logic [31:0]            avs_writedata_i,
   input  wire logic [3:0]             avs_byteenable_i,
   output logic [31:0]                 avs_readdata_o,
   output logic                        avs_waitrequest_o,
   output logic [`MMM_OPW-1:0]         upper_product_half_o,
   output logic [`MMM_OPW-1:0]         lower_product_half_o
);
   mmm_pkg::mmm_bus_state_t state_q;
   mmm_pkg::mmm_bus_state_t state_d;
   logic [31:0]             rdata_q;
   logic [31:0]             rdata_d;
   logic                    shift_q;
   logic                    flow_q;
   logic                    strobed_q;

   mmm_oper_if mcand_if ();
   mmm_oper_if mplier_if ();

   wire req_w    = avs_read_i | avs_write_i;
   // the access completes on the edge where waitrequest is seen low
   wire done_w   = ce_i && req_w && (state_q == mmm_pkg::MMM_BUS_ANSWER);
   wire wr_w     = done_w && avs_write_i;
   wire low_be_w = &avs_byteenable_i[1:0];
   wire hi_be_w  = avs_byteenable_i[2];
   wire sel_x_w  = (avs_address_i == `MMM_OFS_MCAND);
   wire sel_y_w  = (avs_address_i == `MMM_OFS_MPLIER);
   wire sel_c_w  = (avs_address_i == `MMM_OFS_CTRL);
   wire sel_s_w  = (avs_address_i == `MMM_OFS_PSTROBE);
   wire sel_p_w  = (avs_address_i == `MMM_OFS_PRODUCT);
   wire sel_st_w = (avs_address_i == `MMM_OFS_STATUS);
   // a partial write would split operand and select, so it needs all three lanes
   wire ld_x_w   = wr_w && sel_x_w && low_be_w && hi_be_w;       // RULE3
   wire ld_y_w   = wr_w && sel_y_w && low_be_w && hi_be_w;       // RULE3
   wire strobe_w = wr_w && sel_s_w;                              // RULE3

   // a frozen clock holds the answer back, or the master would finish an access never taken
   assign avs_waitrequest_o = req_w && (!ce_i || state_q != mmm_pkg::MMM_BUS_ANSWER);
   assign avs_readdata_o    = rdata_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         mmm_pkg::MMM_BUS_IDLE: begin
            if (req_w) begin
               state_d = mmm_pkg::MMM_BUS_ANSWER;
            end
         end
         mmm_pkg::MMM_BUS_ANSWER: begin
            state_d = mmm_pkg::MMM_BUS_IDLE;
         end
         default: begin
            state_d = mmm_pkg::MMM_BUS_IDLE;
         end
      endcase
   end

   always_comb begin
      rdata_d = `MMM_RST_DATA;
      if (sel_x_w) begin
         rdata_d = {15'h0000, mcand_if.signed_sel, mcand_if.value};
      end else if (sel_y_w) begin
         rdata_d = {15'h0000, mplier_if.signed_sel, mplier_if.value};
      end else if (sel_c_w) begin
         rdata_d = {30'h0000_0000, flow_q, shift_q};
      end else if (sel_p_w) begin
         rdata_d = {upper_product_half_o, lower_product_half_o};
      end else if (sel_st_w) begin
         rdata_d = {31'h0000_0000, strobed_q};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_q <= mmm_pkg::MMM_BUS_IDLE;
         rdata_q <= `MMM_RST_DATA;
      end else if (ce_i) begin
         state_q <= state_d;
         if (avs_read_i && state_q == mmm_pkg::MMM_BUS_IDLE) begin
            rdata_q <= rdata_d;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         shift_q   <= `MMM_RST_SHIFT;  // RULE8
         flow_q    <= `MMM_RST_FLOW;
         strobed_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_w && sel_c_w && avs_byteenable_i[0]) begin
            shift_q <= avs_writedata_i[`MMM_FLD_SHIFT];
            flow_q  <= avs_writedata_i[`MMM_FLD_FLOW];
         end
         if (strobe_w) begin
            strobed_q <= 1'b1;
         end else if (ld_x_w || ld_y_w) begin
            strobed_q <= 1'b0;
         end
      end
   end

   mmm_oper_reg u_mcand (
      .ref_clk_i    (ref_clk_i),
      .rst_n_i      (rst_n_i),
      .ce_i         (ce_i),
      .load_i       (ld_x_w),
      .data_i       (avs_writedata_i[`MMM_OPW-1:0]),
      .signed_sel_i (avs_writedata_i[`MMM_FLD_SIGNED]),
      .oper         (mcand_if.src)
   );

   mmm_oper_reg u_mplier (
      .ref_clk_i    (ref_clk_i),
      .rst_n_i      (rst_n_i),
      .ce_i         (ce_i),
      .load_i       (ld_y_w),
      .data_i       (avs_writedata_i[`MMM_OPW-1:0]),
      .signed_sel_i (avs_writedata_i[`MMM_FLD_SIGNED]),
      .oper         (mplier_if.src)
   );

   mmm_prod_unit u_prod (
      .ref_clk_i            (ref_clk_i),
      .rst_n_i              (rst_n_i),
      .ce_i                 (ce_i),
      .mcand                (mcand_if.dst),
      .mplier               (mplier_if.dst),
      .result_shift_ctl_i   (shift_q),
      .flow_through_ctl_i   (flow_q),
      .strobe_i             (strobe_w),
      .upper_product_half_o (upper_product_half_o),
      .lower_product_half_o (lower_product_half_o)
   );
endmodule : mmm_top

// ---- tb/mmm_chk.sv ----
// Purpose: port checks of mmm_top
// Assumes: shadow state follows accepted bus writes
// Notes: expected product rebuilt from the shadow operands
`timescale 1ns/1ps
module mmm_chk (
   input wire logic        ref_clk_i,
   input wire logic        rst_n_i,
   input wire logic        ce_i,
   input wire logic [4:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic [15:0] upper_product_half_o,
   input wire logic [15:0] lower_product_half_o
);
   logic [16:0] x_q, y_q;
   logic        shift_q, flow_q;
   wire logic acc = ce_i && !avs_waitrequest_o;
   wire logic wr = acc && avs_write_i;
   wire logic rd = acc && avs_read_i;
   wire logic be3 = avs_byteenable_i[2:0] == 3'h7;
   wire logic signed [16:0] xs = {x_q[16] & x_q[15], x_q[15:0]};
   wire logic signed [16:0] ys = {y_q[16] & y_q[15], y_q[15:0]};
   wire logic signed [33:0] q = xs * ys;
   wire logic [31:0] exp_w = shift_q ? q[31:0] : {q[32:17], q[32], q[16:2]};
   wire logic [31:0] out_w = {upper_product_half_o, lower_product_half_o};
   // product register loads on a strobe, or every enabled edge in flow-through
   wire logic upd = (wr && avs_address_i == 5'h0C) || (flow_q && ce_i);
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         x_q <= 17'h0;
         y_q <= 17'h0;
         shift_q <= 1'b1;
         flow_q <= 1'b0;
      end else if (wr) begin
         if (avs_address_i == 5'h00 && be3) x_q <= avs_writedata_i[16:0];
         if (avs_address_i == 5'h04 && be3) y_q <= avs_writedata_i[16:0];
         if (avs_address_i == 5'h08 && avs_byteenable_i[0])
            {flow_q, shift_q} <= avs_writedata_i[1:0];
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_wait_one: assert property ((avs_read_i || avs_write_i)
      && !$past(avs_read_i || avs_write_i)
      && ce_i |-> avs_waitrequest_o ##1 (!avs_waitrequest_o || !ce_i)) else $error("no answer");
   a_idle_low: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("wait while idle");
   a_upper_val: assert property ($past(upd) |-> out_w[31:16] == $past(exp_w[31:16]))
      else $error("upper half wrong");
   a_lower_val: assert property ($past(upd) |-> out_w[15:0] == $past(exp_w[15:0]))
      else $error("lower half wrong");
   a_sign_copy: assert property ($past(upd && !shift_q) |-> out_w[15] == out_w[31])
      else $error("sign copy missing");
   a_hold_out: assert property (!$past(upd) |-> $stable(out_w))
      else $error("product moved");
   a_unmapped_rd: assert property (rd && avs_address_i >= 5'h18
      |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
   a_ctrl_rd: assert property (rd && avs_address_i == 5'h08
      |-> avs_readdata_o == {30'h0, flow_q, shift_q}) else $error("control readback wrong");
   cover property ($past(wr && avs_address_i == 5'h0C && !shift_q));
   cover property (flow_q && $past(flow_q) && $changed(out_w));
   cover property (rd && avs_address_i >= 5'h18);
endmodule : mmm_chk
bind mmm_top mmm_chk mmm_chk_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .upper_product_half_o(upper_product_half_o), .lower_product_half_o(lower_product_half_o));

// ---- tb/mmm_host.sv ----
// Purpose: system logic that loads operands and strobes the product
// Assumes: avalon master, one request at a time
// Notes: waits for the answer without a limit; the bench watchdog ends a hang
`timescale 1ns/1ps
module mmm_host (
   input  wire logic        ref_clk_i,
   input  wire logic        avs_waitrequest_i,
   input  wire logic [31:0] avs_readdata_i,
   output logic [4:0]       avs_address_o,
   output logic             avs_read_o,
   output logic             avs_write_o,
   output logic [31:0]      avs_writedata_o,
   output logic [3:0]       avs_byteenable_o
);
   initial begin
      {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o} = '0;
      avs_byteenable_o = 4'hF;
   end
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge ref_clk_i);
      avs_address_o <= a;
      avs_writedata_o <= d;
      avs_write_o <= wr;
      avs_read_o <= !wr;
      do begin
         @(posedge ref_clk_i);
      end while (avs_waitrequest_i !== 1'b0);
      r = avs_readdata_i;
      avs_write_o <= 1'b0;
      avs_read_o <= 1'b0;
   endtask : bus
   // lanes change only between requests, never while one stands
   task automatic set_be(input logic [3:0] b);
      avs_byteenable_o <= b;
   endtask : set_be
   task automatic mul(input logic ld, input logic [15:0] a, input logic sa,
                      input logic [15:0] b, input logic sb, input logic [1:0] ctl);
      logic [31:0] r;
      if (ld) bus(1'b1, 5'h00, {15'h0, sa, a}, r);
      bus(1'b1, 5'h04, {15'h0, sb, b}, r);
      bus(1'b1, 5'h08, {30'h0, ctl}, r);
      bus(1'b1, 5'h0C, 32'h0, r);
   endtask : mul
endmodule : mmm_host

// ---- tb/mmm_top_tb.sv ----
// Purpose: self-checking bench of mmm_top
// Assumes: 250 MHz clock, synchronous reset
// Notes: a skipped multiplicand load keeps it as a constant
`timescale 1ns/1ps
module mmm_top_tb;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic [4:0] adr;
   logic rd, wr, wt;
   logic [31:0] wd, rdat;
   logic [3:0] be;
   logic [15:0] up, lo;
   int error_cnt = 0;
   int cmp_count = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   mmm_top mmm_top_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
      .upper_product_half_o(up), .lower_product_half_o(lo));
   mmm_host mmm_host_inst (.ref_clk_i(ref_clk_i), .avs_waitrequest_i(wt),
      .avs_readdata_i(rdat), .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr),
      .avs_writedata_o(wd), .avs_byteenable_o(be));
   function automatic logic [31:0] expect_p(logic [15:0] a, logic sa, logic [15:0] b,
                                            logic sb, logic shf);
      logic signed [33:0] q;
      q = $signed({sa & a[15], a}) * $signed({sb & b[15], b});
      return shf ? q[31:0] : {q[32:17], q[32], q[16:2]};
   endfunction : expect_p
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic end_sim;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      error_cnt++;
      end_sim();
   end
   initial begin
      logic [31:0] r;
      logic [15:0] a, b;
      logic sa, sb, shf, ld;
      void'($urandom(32'h50CDF937));
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      mmm_host_inst.bus(1'b0, 5'h08, 32'h0, r);
      chk("ctrl reset", 32'h1, r);
      mmm_host_inst.bus(1'b0, 5'h18, 32'h0, r);
      chk("unmapped", 32'h0, r);
      for (int i = 0; i < 40; i++) begin
         ld = i < 2 || i % 4 == 0;
         if (ld) begin
            a = (i < 2) ? 16'h8000 : 16'($urandom);
            sa = (i < 2) | 1'($urandom);
         end
         b = (i < 2) ? 16'h8000 : 16'($urandom);
         sb = (i < 2) | 1'($urandom);
         shf = (i == 1) ? 1'b0 : 1'($urandom);
         if (!sa && !sb) shf = 1'b1;
         mmm_host_inst.mul(ld, a, sa, b, sb, {1'b0, shf});
         @(posedge ref_clk_i);
         chk("outputs", expect_p(a, sa, b, sb, shf), {up, lo});
         mmm_host_inst.bus(1'b0, 5'h10, 32'h0, r);
         chk("product word", expect_p(a, sa, b, sb, shf), r);
         mmm_host_inst.bus(1'b0, 5'h14, 32'h0, r);
         chk("strobed", 32'h1, r);
         mmm_host_inst.bus(1'b0, 5'h00, 32'h0, r);
         chk("mcand held", {15'h0, sa, a}, r);
      end
      // a write missing a lane must leave operand and select untouched
      mmm_host_inst.set_be(4'h3);
      mmm_host_inst.bus(1'b1, 5'h00, 32'h1FFFF, r);
      mmm_host_inst.set_be(4'hF);
      mmm_host_inst.bus(1'b0, 5'h00, 32'h0, r);
      chk("partial write", {15'h0, sa, a}, r);
      mmm_host_inst.bus(1'b1, 5'h08, 32'h3, r);
      mmm_host_inst.bus(1'b1, 5'h00, 32'h1FFFF, r);
      mmm_host_inst.bus(1'b1, 5'h04, 32'h00007, r);
      repeat (2) @(posedge ref_clk_i);
      chk("flow", expect_p(16'hFFFF, 1'b1, 16'h7, 1'b0, 1'b1), {up, lo});
      // low enable stalls a pending write and freezes the flow-through register
      ce_i <= 1'b0;
      fork
         mmm_host_inst.bus(1'b1, 5'h00, 32'h00003, r);
         begin
            repeat (4) @(posedge ref_clk_i);
            chk("frozen", expect_p(16'hFFFF, 1'b1, 16'h7, 1'b0, 1'b1), {up, lo});
            ce_i <= 1'b1;
         end
      join
      repeat (2) @(posedge ref_clk_i);
      chk("flow reload", expect_p(16'h3, 1'b0, 16'h7, 1'b0, 1'b1), {up, lo});
      mmm_host_inst.bus(1'b0, 5'h14, 32'h0, r);
      chk("strobed clear", 32'h0, r);
      end_sim();
   end
endmodule : mmm_top_tb
